// file: pmel_map.svh
`ifndef PMEL_MAP_SVH
`define PMEL_MAP_SVH
// register word indices, byte address is four times the index
`define PMEL_IDX_MODE 10'h000
`define PMEL_IDX_STAT0 10'h001
`define PMEL_IDX_STAT1 10'h002
`define PMEL_IDX_FEN0 10'h003
`define PMEL_IDX_FEN1 10'h004
`define PMEL_IDX_DETCTL 10'h010
`define PMEL_IDX_ZXCFG 10'h011
`define PMEL_IDX_SAGTH 10'h012
`define PMEL_IDX_PLTH 10'h013
`define PMEL_IDX_NTH 10'h020
// partial measurement access window and special indices
`define PMEL_PM_LO 10'h014
`define PMEL_PM_HI 10'h01D
`define PMEL_SPC_A 10'h000
`define PMEL_SPC_B 10'h001
`define PMEL_SPC_C 10'h003
`define PMEL_SPC_D 10'h007
`define PMEL_SPC_E 10'h00E
`define PMEL_SPC_F 10'h00F
// field positions
`define PMEL_SAG_BIT 3
`define PMEL_NOV_BIT 15
// mode pin codes
`define PMEL_PINS_NORMAL 2'b11
`define PMEL_PINS_PARTIAL 2'b10
`define PMEL_PINS_DETECT 2'b01
`define PMEL_PINS_IDLE 2'b00
// reset values
`define PMEL_DETCTL_RST 6'h3F
`define PMEL_ZXCFG_RST 12'hA98
`define PMEL_SAGTH_RST 16'h0000
`define PMEL_PLTH_RST 16'h0000
`define PMEL_NTH_RST 16'hFFFF
// timing
`define PMEL_CLK_HZ 100000000
`define PMEL_SMP_HZ 8000
`define PMEL_WIN_MS 11
`define PMEL_SAG_MIN 3
`endif

// file: pmel_pkg.sv
package pmel_pkg;
   typedef enum logic [1:0] {pm_idle, pm_detect, pm_partial, pm_normal} pmel_mode_t;

   typedef struct packed {
      logic en;
      logic [2:0] sel;
   } pmel_zx_field_t;

   typedef struct packed {
      logic volt_adc;
      logic neutral_adc;
      logic current_adc;
      logic core;
      logic current_det;
      logic pms;
      logic osc;
   } pmel_pwr_en_t;
endpackage : pmel_pkg

// file: pmel_power_mode.sv
`timescale 1ns/1ps
`include "pmel_map.svh"
// Summary of operation
// - mode taken only from two select pins
// - normal: all blocks on but current detector
// - idle: measurement off, mode pins stay live
// - idle: serial pins inputs, outputs driven low
// - idle: oscillator off, crystal output low
// - detect: compare each phase against threshold
// - detect: any phase over latches first irq
// - detect: all phases over latch second irq
// - detect irqs cleared entering and leaving detect
// - detect pins as idle except irqs
// - per-phase pos/neg comparators, individually disabled
// - partial: measure one cycle, then first irq
// - partial: only listed registers are accessible
// - every mode change passes through idle
// - per-phase voltage/current zero crossing, configurable outputs
// - sag: two windows with under three hits
// - sag sets flag b3, irq if enabled
// - phase loss uses sag method, own threshold
// - lost phase disables its zero crossings
// - neutral over threshold sets b15, irq if enabled
module pmel_power_mode #(
   parameter int SAMPLE_DIV = `PMEL_CLK_HZ / `PMEL_SMP_HZ
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // mode pins and analog pins
   input wire logic mode_select_hi,
   input wire logic mode_select_lo,
   input wire logic [2:0] cmp_pos,
   input wire logic [2:0] cmp_neg,
   input wire logic osc_in,
   // measurement path, same clock
   input wire logic [2:0][15:0] volt_abs,
   input wire logic [5:0] fund_sign,
   input wire logic pms_cur_sign,
   input wire logic [15:0] neutral_rms,
   input wire logic neutral_rms_vld,
   // core requests for gated pins
   input wire logic [3:0] cf_req,
   input wire logic warn_req,
   input wire logic [3:0] spi_oe_req,
   // pins and power control
   output logic zero_cross_out_0,
   output logic zero_cross_out_1,
   output logic zero_cross_out_2,
   output logic energy_pulse_out_1,
   output logic energy_pulse_out_2,
   output logic energy_pulse_out_3,
   output logic energy_pulse_out_4,
   output logic warning_pin,
   output logic first_interrupt_pin,
   output logic second_interrupt_pin,
   output logic crystal_out_pin,
   output logic [3:0] spi_oe,
   output logic [5:0] det_comp_en,
   output pmel_pkg::pmel_pwr_en_t pwr_en,
   output pmel_pkg::pmel_mode_t power_mode
);
   localparam int WIN_SAMPLES = `PMEL_WIN_MS * `PMEL_SMP_HZ / 1000;
   function automatic pmel_pkg::pmel_mode_t pins_to_mode(input logic [1:0] p);
      pins_to_mode = pmel_pkg::pm_idle;
      unique case (p)
         `PMEL_PINS_NORMAL: pins_to_mode = pmel_pkg::pm_normal;
         `PMEL_PINS_PARTIAL: pins_to_mode = pmel_pkg::pm_partial;
         `PMEL_PINS_DETECT: pins_to_mode = pmel_pkg::pm_detect;
         `PMEL_PINS_IDLE: pins_to_mode = pmel_pkg::pm_idle;
      endcase
   endfunction : pins_to_mode
   function automatic logic is_mapped(input logic [9:0] i);
      is_mapped = (i == `PMEL_IDX_MODE) || (i == `PMEL_IDX_STAT0) || (i == `PMEL_IDX_STAT1) ||
                  (i == `PMEL_IDX_FEN0) || (i == `PMEL_IDX_FEN1) || (i == `PMEL_IDX_DETCTL) ||
                  (i == `PMEL_IDX_ZXCFG) || (i == `PMEL_IDX_SAGTH) || (i == `PMEL_IDX_PLTH) ||
                  (i == `PMEL_IDX_NTH);
   endfunction : is_mapped
   function automatic logic pm_allowed(input logic [9:0] i);
      pm_allowed = (i >= `PMEL_PM_LO && i <= `PMEL_PM_HI) || (i == `PMEL_SPC_A) ||
                   (i == `PMEL_SPC_B) || (i == `PMEL_SPC_C) || (i == `PMEL_SPC_D) ||
                   (i == `PMEL_SPC_E) || (i == `PMEL_SPC_F);
   endfunction : pm_allowed
   // phase of a zero-crossing source, sources 6 and 7 fold onto phase a
   function automatic logic [1:0] zx_phase(input logic [2:0] s);
      zx_phase = (s < 3'h3) ? s[1:0] : ((s < 3'h6) ? 2'(s - 3'h3) : 2'h0);
   endfunction : zx_phase
   logic [1:0] pm_s1_q, pm_s2_q, pm_edges_q;
   logic [5:0] cmp_s1_q, cmp_s2_q, detctl_q;
   logic osc_s1_q, osc_s2_q, mode_chg, is_norm, is_det, is_part, det_first_interrupt_pin_q, det_second_interrupt_pin_q, pms_sign_q;
   logic pm_done, smp_stb, win_end, stat0_sag_q, stat1_nov_q, fen0_q, fen1_q, acc, reg_ok, wr_en;
   pmel_pkg::pmel_mode_t mode_q, mode_d, pin_mode;
   logic [2:0] exceed, sag_prev_q, pl_prev_q, phase_lost_q, sag_evt, zx_q;
   logic [13:0] smp_cnt_q;
   logic [7:0] win_cnt_q;
   logic [1:0] sag_cnt_q [3], pl_cnt_q [3];
   pmel_pkg::pmel_zx_field_t [2:0] zxcfg_q;
   logic [15:0] sagth_q, plth_q, nth_q;
   logic [9:0] idx;
   logic [31:0] rd_data;
   ////////////////////////////////////////////////////////////////////////////////////////////
   // synchronisers; the host keeps every input at a valid level even in idle
   // valid input levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {pm_s1_q, pm_s2_q, cmp_s1_q, cmp_s2_q, osc_s1_q, osc_s2_q} <= 18'h0_0000;
      end else begin
         pm_s1_q <= {mode_select_hi, mode_select_lo};
         pm_s2_q <= pm_s1_q;
         cmp_s1_q <= {cmp_neg, cmp_pos};
         cmp_s2_q <= cmp_s1_q;
         osc_s1_q <= osc_in;
         osc_s2_q <= osc_s1_q;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   // power mode
   always_comb begin
      pin_mode = pins_to_mode(pm_s2_q);
      mode_d = pin_mode;
      if (mode_q != pmel_pkg::pm_idle && pin_mode != pmel_pkg::pm_idle && pin_mode != mode_q) begin
         mode_d = pmel_pkg::pm_idle;
      end
   end
   assign mode_chg = (mode_d != mode_q);
   assign is_norm = (mode_q == pmel_pkg::pm_normal);
   assign is_det = (mode_q == pmel_pkg::pm_detect);
   assign is_part = (mode_q == pmel_pkg::pm_partial);
   assign power_mode = mode_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= pmel_pkg::pm_idle;
      end else begin
         mode_q <= mode_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   // current detector
   // per-side comparator enables
   assign exceed = (cmp_s2_q[2:0] & detctl_q[2:0]) | (cmp_s2_q[5:3] & detctl_q[5:3]);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {det_first_interrupt_pin_q, det_second_interrupt_pin_q} <= 2'h0;
      end else if (mode_chg) begin
         {det_first_interrupt_pin_q, det_second_interrupt_pin_q} <= 2'h0;
      end else if (is_det) begin
         if (|exceed) begin
            det_first_interrupt_pin_q <= 1'b1;
         end
         if (&exceed) begin
            det_second_interrupt_pin_q <= 1'b1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   // partial measurement: one full line cycle spans two rising current crossings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pms_sign_q <= 1'b0;
         pm_edges_q <= 2'h0;
      end else begin
         pms_sign_q <= pms_cur_sign;
         if (mode_chg || !is_part) begin
            pm_edges_q <= 2'h0;
         end else if (pms_cur_sign && !pms_sign_q && pm_edges_q != 2'h2) begin
            pm_edges_q <= pm_edges_q + 2'h1;
         end
      end
   end
   assign pm_done = (pm_edges_q == 2'h2);
   ////////////////////////////////////////////////////////////////////////////////////////////
   // 8 kHz sample strobe and 11 ms window, running in normal mode only
   assign smp_stb = is_norm && (smp_cnt_q == 14'(SAMPLE_DIV - 1));
   assign win_end = (win_cnt_q == 8'(WIN_SAMPLES - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smp_cnt_q <= 14'h0000;
         win_cnt_q <= 8'h00;
      end else if (!is_norm) begin
         smp_cnt_q <= 14'h0000;
         win_cnt_q <= 8'h00;
      end else if (smp_stb) begin
         smp_cnt_q <= 14'h0000;
         win_cnt_q <= win_end ? 8'h00 : win_cnt_q + 8'h01;
      end else begin
         smp_cnt_q <= smp_cnt_q + 14'h0001;
      end
   end
   for (genvar g = 0; g < 3; g++) begin : g_phase
      logic sag_hit, pl_hit, sag_low, pl_low;
      logic [1:0] sag_nx, pl_nx;
      assign sag_hit = volt_abs[g] > sagth_q;
      assign pl_hit = volt_abs[g] > plth_q;
      assign sag_nx = (sag_cnt_q[g] == 2'h3) ? 2'h3 : sag_cnt_q[g] + {1'b0, sag_hit};
      assign pl_nx = (pl_cnt_q[g] == 2'h3) ? 2'h3 : pl_cnt_q[g] + {1'b0, pl_hit};
      assign sag_low = (sag_nx < 2'(`PMEL_SAG_MIN));
      assign pl_low = (pl_nx < 2'(`PMEL_SAG_MIN));
      assign sag_evt[g] = smp_stb && win_end && sag_low && sag_prev_q[g];
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            {sag_cnt_q[g], pl_cnt_q[g], sag_prev_q[g], pl_prev_q[g], phase_lost_q[g]} <= 7'h00;
         end else if (!is_norm) begin
            {sag_cnt_q[g], pl_cnt_q[g], sag_prev_q[g], pl_prev_q[g], phase_lost_q[g]} <= 7'h00;
         end else if (smp_stb) begin
            sag_cnt_q[g] <= win_end ? 2'h0 : sag_nx;
            pl_cnt_q[g] <= win_end ? 2'h0 : pl_nx;
            if (win_end) begin
               sag_prev_q[g] <= sag_low;
               pl_prev_q[g] <= pl_low;
               phase_lost_q[g] <= pl_low && pl_prev_q[g];
            end
         end
      end
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            zx_q[g] <= 1'b0;
         end else begin
            zx_q[g] <= is_norm && zxcfg_q[g].en && zxcfg_q[g].sel < 3'h6 &&
                       !phase_lost_q[zx_phase(zxcfg_q[g].sel)] && fund_sign[zxcfg_q[g].sel];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   // event flags; a set in the cycle of a clear wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {stat0_sag_q, stat1_nov_q} <= 2'h0;
      end else begin
         if (|sag_evt) begin
            stat0_sag_q <= 1'b1;
         end else if (wr_en && idx == `PMEL_IDX_STAT0 && pwdata[`PMEL_SAG_BIT]) begin
            stat0_sag_q <= 1'b0;
         end
         if (is_norm && neutral_rms_vld && neutral_rms > nth_q) begin
            stat1_nov_q <= 1'b1;
         end else if (wr_en && idx == `PMEL_IDX_STAT1 && pwdata[`PMEL_NOV_BIT]) begin
            stat1_nov_q <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   // pin gating; detect keeps idle pin states apart from the irqs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {first_interrupt_pin, second_interrupt_pin, warning_pin, crystal_out_pin} <= 4'h0;
         {energy_pulse_out_4, energy_pulse_out_3, energy_pulse_out_2, energy_pulse_out_1} <= 4'h0;
         {spi_oe, det_comp_en} <= 10'h000;
         pwr_en <= '0;
      end else begin
         first_interrupt_pin <= (is_det && det_first_interrupt_pin_q) || (is_part && pm_done) ||
                                (is_norm && stat0_sag_q && fen0_q);
         second_interrupt_pin <= (is_det && det_second_interrupt_pin_q) || (is_norm && stat1_nov_q && fen1_q);
         {energy_pulse_out_4, energy_pulse_out_3, energy_pulse_out_2, energy_pulse_out_1} <=
            is_norm ? cf_req : 4'h0;
         warning_pin <= is_norm && warn_req;
         spi_oe <= (is_norm || is_part) ? spi_oe_req : 4'h0;
         crystal_out_pin <= (is_norm || is_part) && osc_s2_q;
         det_comp_en <= is_det ? detctl_q : 6'h00;
         pwr_en.volt_adc <= is_norm;
         pwr_en.neutral_adc <= is_norm;
         pwr_en.current_adc <= is_norm || is_part;
         pwr_en.core <= is_norm;
         pwr_en.current_det <= is_det;
         pwr_en.pms <= is_norm || is_part;
         pwr_en.osc <= is_norm || is_part;
      end
   end
   assign zero_cross_out_0 = zx_q[0];
   assign zero_cross_out_1 = zx_q[1];
   assign zero_cross_out_2 = zx_q[2];
   ////////////////////////////////////////////////////////////////////////////////////////////
   // apb slave; read data is captured in setup so access completes without wait
   assign idx = paddr[11:2];
   assign acc = psel && penable;
   assign reg_ok = is_mapped(idx) && (is_norm || (is_part && pm_allowed(idx)));
   assign wr_en = acc && pwrite && reg_ok;
   assign pready = 1'b1;
   assign pslverr = acc && !reg_ok;
   always_comb begin
      rd_data = 32'h0000_0000;
      unique case (idx)
         `PMEL_IDX_MODE: rd_data[3:0] = {mode_q, pm_s2_q};
         `PMEL_IDX_STAT0: rd_data[`PMEL_SAG_BIT:0] = {stat0_sag_q, phase_lost_q};
         `PMEL_IDX_STAT1: rd_data[`PMEL_NOV_BIT] = stat1_nov_q;
         `PMEL_IDX_FEN0: rd_data[`PMEL_SAG_BIT] = fen0_q;
         `PMEL_IDX_FEN1: rd_data[`PMEL_NOV_BIT] = fen1_q;
         `PMEL_IDX_DETCTL: rd_data[5:0] = detctl_q;
         `PMEL_IDX_ZXCFG: rd_data[11:0] = zxcfg_q;
         `PMEL_IDX_SAGTH: rd_data[15:0] = sagth_q;
         `PMEL_IDX_PLTH: rd_data[15:0] = plth_q;
         `PMEL_IDX_NTH: rd_data[15:0] = nth_q;
         default: rd_data = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= (!pwrite && reg_ok) ? rd_data : 32'h0000_0000;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {fen0_q, fen1_q} <= 2'h0;
         detctl_q <= `PMEL_DETCTL_RST;
         zxcfg_q <= `PMEL_ZXCFG_RST;
         sagth_q <= `PMEL_SAGTH_RST;
         plth_q <= `PMEL_PLTH_RST;
         nth_q <= `PMEL_NTH_RST;
      end else if (wr_en) begin
         unique case (idx)
            `PMEL_IDX_FEN0: fen0_q <= pwdata[`PMEL_SAG_BIT];
            `PMEL_IDX_FEN1: fen1_q <= pwdata[`PMEL_NOV_BIT];
            `PMEL_IDX_DETCTL: detctl_q <= pwdata[5:0];
            `PMEL_IDX_ZXCFG: zxcfg_q <= pwdata[11:0];
            `PMEL_IDX_SAGTH: sagth_q <= pwdata[15:0];
            `PMEL_IDX_PLTH: plth_q <= pwdata[15:0];
            `PMEL_IDX_NTH: nth_q <= pwdata[15:0];
            default: ;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_mode_via_idle: assert property (
      (mode_q != pmel_pkg::pm_idle && $past(mode_q) != pmel_pkg::pm_idle) |-> mode_q == $past(mode_q))
      else $error("mode moved between two active modes");
   a_mode_from_pins: assert property (
      (mode_q == pmel_pkg::pm_idle && pins_to_mode(pm_s2_q) != pmel_pkg::pm_idle)
      |=> mode_q == pins_to_mode($past(pm_s2_q)))
      else $error("mode did not follow pins from idle");
   a_idle_pins_low: assert property (
      (mode_q == pmel_pkg::pm_idle) [*2] |-> (spi_oe == 4'h0 && !warning_pin && !first_interrupt_pin &&
      !second_interrupt_pin && !energy_pulse_out_1 && !zero_cross_out_0))
      else $error("pin active in idle");
   a_osc_idle_off: assert property (
      $past(mode_q) == pmel_pkg::pm_idle |-> (!crystal_out_pin && !pwr_en.osc))
      else $error("oscillator running in idle");
   a_det_any_irq: assert property (
      (is_det && !mode_chg && |exceed) |=> ##1 first_interrupt_pin)
      else $error("first irq missing in detect");
   a_det_all_irq: assert property (
      (is_det && !mode_chg && &exceed) |=> det_second_interrupt_pin_q)
      else $error("second irq not latched");
   a_det_clear: assert property (
      mode_chg |=> (!det_first_interrupt_pin_q && !det_second_interrupt_pin_q))
      else $error("detect irq survived mode change");
   a_pm_refuse: assert property (
      (acc && is_part && !pm_allowed(idx)) |-> pslverr)
      else $error("partial mode access not refused");
   a_sag_irq: assert property (
      (|sag_evt && fen0_q && is_norm && !mode_chg) |=> ##1 first_interrupt_pin)
      else $error("sag irq missing");
   a_zx_lost: assert property (
      (phase_lost_q[0] && zxcfg_q[0].sel == 3'h0) |=> !zero_cross_out_0)
      else $error("zero cross on lost phase");
   a_nov_flag: assert property (
      (is_norm && neutral_rms_vld && neutral_rms > nth_q) |=> stat1_nov_q)
      else $error("neutral over flag not set");
   c_det_all: cover property (is_det && det_second_interrupt_pin_q);
   c_part_done: cover property (is_part && first_interrupt_pin);
   c_sag_event: cover property (|sag_evt);
   c_pm_refused: cover property (acc && is_part && pslverr);
endmodule : pmel_power_mode

// file: pmel_mcu_model.sv
`timescale 1ns/1ps
module pmel_mcu_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // wanted pin code
   input wire logic [1:0] want,
   // mode pins and status
   output logic mode_select_hi,
   output logic mode_select_lo,
   output logic settled
);
   logic [1:0] pins_q;
   logic [3:0] cnt_q;
   assign {mode_select_hi, mode_select_lo} = pins_q;
   assign settled = pins_q == want && cnt_q == 4'h0;
   ////////////////////////////////////////
   // pins always driven, via idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_q <= 2'h0;
         cnt_q <= 4'h0;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end else if (pins_q != want) begin
         // dwell covers pin sync plus output update
         cnt_q <= 4'h7;
         pins_q <= pins_q != 2'h0 && want != 2'h0 ? 2'h0 : want;
      end
   end
endmodule : pmel_mcu_model

// file: tb_top.sv
`timescale 1ns/1ps
`include "pmel_map.svh"
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, osc_in, pms_cur_sign, neutral_rms_vld;
   logic warn_req, mode_select_hi, mode_select_lo, settled, warning_pin, crystal_out_pin, err;
   logic zero_cross_out_0, zero_cross_out_1, zero_cross_out_2, first_interrupt_pin, second_interrupt_pin;
   logic energy_pulse_out_1, energy_pulse_out_2, energy_pulse_out_3, energy_pulse_out_4;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] cmp_pos, cmp_neg;
   logic [2:0][15:0] volt_abs;
   logic [5:0] fund_sign, det_comp_en;
   logic [15:0] neutral_rms;
   logic [3:0] cf_req, spi_oe_req, spi_oe;
   logic [1:0] want, irq;
   pmel_pkg::pmel_pwr_en_t pwr_en;
   pmel_pkg::pmel_mode_t power_mode;
   int num_errors = 0;
   int samples_checked = 0;
   int n;
   assign irq = {first_interrupt_pin, second_interrupt_pin};
   pmel_power_mode #(.SAMPLE_DIV(20)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .mode_select_hi, .mode_select_lo, .cmp_pos, .cmp_neg, .osc_in,
      .volt_abs, .fund_sign, .pms_cur_sign, .neutral_rms, .neutral_rms_vld, .cf_req, .warn_req,
      .spi_oe_req, .zero_cross_out_0, .zero_cross_out_1, .zero_cross_out_2, .energy_pulse_out_1,
      .energy_pulse_out_2, .energy_pulse_out_3, .energy_pulse_out_4, .warning_pin,
      .first_interrupt_pin, .second_interrupt_pin, .crystal_out_pin, .spi_oe, .det_comp_en, .pwr_en,
      .power_mode);
   pmel_mcu_model i_mcu (.pclk, .presetn, .want, .mode_select_hi, .mode_select_lo, .settled);
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic end_of_test();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test
   // ends on a falling edge so outputs are settled when read
   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
      @(negedge pclk);
   endtask : cyc
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
      int w;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (w = 0; w < 16; w++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (w == 16) begin
         num_errors++;
         end_of_test();
      end
   endtask : apb
   task automatic go(input logic [1:0] m);
      int w;
      @(posedge pclk);
      want <= m;
      @(posedge pclk);
      for (w = 0; w < 40 && settled !== 1'b1; w++) @(posedge pclk);
      if (w == 40) begin
         num_errors++;
         end_of_test();
      end
      cyc(2);
   endtask : go
   task automatic cmp(input logic [2:0] p, input logic [2:0] q);
      @(posedge pclk);
      cmp_pos <= p;
      cmp_neg <= q;
      cyc(6);
   endtask : cmp
   ////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, pms_cur_sign, neutral_rms_vld, cmp_pos, cmp_neg} = '0;
      {paddr, pwdata, neutral_rms, want} = '0;
      {osc_in, warn_req, cf_req, spi_oe_req, fund_sign} = '1;
      volt_abs = '1;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      cyc(2);
      chk("idle pins", {power_mode, crystal_out_pin, zero_cross_out_0, energy_pulse_out_1, irq, spi_oe}, '0);
      chk("idle outs", {warning_pin, energy_pulse_out_4, energy_pulse_out_3, energy_pulse_out_2}, '0);
      chk("idle zx pwr", {zero_cross_out_1, zero_cross_out_2, pwr_en}, '0);
      apb(1'b0, `PMEL_IDX_MODE, '0);
      chk("idle access", err, 1'b1);
      $display("test idle done");
      go(`PMEL_PINS_NORMAL);
      chk("normal", {power_mode, pwr_en.core, pwr_en.current_det, crystal_out_pin, zero_cross_out_0}, 6'h3B);
      chk("pulse", energy_pulse_out_1, 1'b1);
      chk("normal outs", {energy_pulse_out_4, energy_pulse_out_3, energy_pulse_out_2, warning_pin}, 4'hF);
      chk("normal zx", {zero_cross_out_1, zero_cross_out_2, spi_oe, pready}, 7'h7F);
      chk("normal pwr", pwr_en, 7'h7B);
      apb(1'b0, `PMEL_IDX_MODE, '0);
      chk("mode reg", rd, 32'h0000_000F);
      apb(1'b0, `PMEL_IDX_DETCTL, '0);
      chk("detctl", rd, 32'h0000_003F);
      apb(1'b0, `PMEL_IDX_ZXCFG, '0);
      chk("zxcfg", rd, 32'h0000_0A98);
      apb(1'b0, 10'h3FF, '0);
      chk("unmapped", err, 1'b1);
      $display("test normal done");
      go(`PMEL_PINS_DETECT);
      chk("detect", {power_mode, det_comp_en, spi_oe, crystal_out_pin, energy_pulse_out_1}, 14'h1FC0);
      chk("detect pwr", pwr_en, 7'h04);
      cmp(3'h1, 3'h0);
      chk("one over", irq, 2'h2);
      cmp(3'h7, 3'h0);
      chk("all over", irq, 2'h3);
      cmp(3'h0, 3'h0);
      chk("irq held", irq, 2'h3);
      go(`PMEL_PINS_IDLE);
      chk("irq leave", irq, 2'h0);
      go(`PMEL_PINS_DETECT);
      chk("irq enter", irq, 2'h0);
      go(`PMEL_PINS_NORMAL);
      apb(1'b1, `PMEL_IDX_DETCTL, 32'h0000_0038);
      go(`PMEL_PINS_DETECT);
      chk("single en", det_comp_en, 6'h38);
      cmp(3'h7, 3'h0);
      chk("pos off", irq, 2'h0);
      cmp(3'h7, 3'h2);
      chk("neg on", irq, 2'h2);
      cmp(3'h0, 3'h0);
      $display("test detect done");
      go(`PMEL_PINS_PARTIAL);
      chk("partial", {pwr_en.volt_adc, pwr_en.neutral_adc, pwr_en.core, irq}, 5'h00);
      chk("partial pwr", pwr_en, 7'h13);
      repeat (2) begin
         @(posedge pclk);
         pms_cur_sign <= 1'b1;
         cyc(3);
         @(posedge pclk);
         pms_cur_sign <= 1'b0;
         cyc(3);
      end
      chk("measured", irq, 2'h2);
      apb(1'b0, `PMEL_IDX_MODE, '0);
      chk("special", err, 1'b0);
      chk("mode partial", rd, 32'h0000_000A);
      apb(1'b0, `PMEL_IDX_DETCTL, '0);
      chk("blocked", err, 1'b1);
      $display("test partial done");
      @(posedge pclk);
      volt_abs <= '0;
      go(`PMEL_PINS_NORMAL);
      apb(1'b1, `PMEL_IDX_FEN0, 32'h0000_0008);
      for (n = 0; n < 4000 && first_interrupt_pin !== 1'b1; n++) @(posedge pclk);
      chk("sag wait", n < 4000, 1'b1);
      if (n == 4000) end_of_test();
      cyc(1);
      chk("zx lost", {zero_cross_out_0, zero_cross_out_1, zero_cross_out_2}, 3'h0);
      apb(1'b0, `PMEL_IDX_STAT0, '0);
      chk("status", rd, 32'h0000_000F);
      apb(1'b1, `PMEL_IDX_STAT0, 32'h0000_0008);
      apb(1'b0, `PMEL_IDX_STAT0, '0);
      chk("sag clear", rd, 32'h0000_0007);
      $display("test sag done");
      apb(1'b1, `PMEL_IDX_NTH, 32'h0000_0010);
      apb(1'b1, `PMEL_IDX_FEN1, 32'h0000_8000);
      @(posedge pclk);
      neutral_rms <= 16'h0020;
      neutral_rms_vld <= 1'b1;
      @(posedge pclk);
      neutral_rms_vld <= 1'b0;
      cyc(4);
      chk("neutral irq", second_interrupt_pin, 1'b1);
      apb(1'b0, `PMEL_IDX_STAT1, '0);
      chk("neutral flag", rd, 32'h0000_8000);
      $display("test neutral done");
      end_of_test();
   end
endmodule : tb_top
